//--- logic/lsbd_pkg.sv
// constants, types and state layout of the lamp sequencer and burst dimmer
// assumes one 40 MHz clock and a single AHB-Lite master in front of the slave
package lsbd_pkg;

  // synchroniser slots, one per asynchronous input
  localparam int SYNC_N = 11;
  localparam int SI_ENABLE = 0;
  localparam int SI_UNDERVOLTAGE_LOCKOUT = 1;
  localparam int SI_LAMP = 2;
  localparam int SI_OV = 3;
  localparam int SI_RAMP = 4;
  localparam int SI_DIMCLK = 5;
  localparam int SI_DM_HI = 6;
  localparam int SI_DM_LO = 7;
  localparam int SI_DV_HI = 8;
  localparam int SI_DV_LO = 9;
  localparam int SI_PWM = 10;

  // sequencing counts, in run-frequency periods
  localparam int TICK_W = 18;
  localparam int unsigned POD_TICKS_DEF = 16384;
  localparam int unsigned STRIKE_LIMIT_DEF = 245760;
  localparam int unsigned RUN_WINDOW_DEF = 8192;
  localparam logic [3:0] IGNITE_CYCLES = 4'h8;
  localparam logic [3:0] RUN_MIN_PULSES = 4'h8;
  localparam logic [3:0] PULSES_PER_STEP_LAST = 4'hF;
  localparam int STEP_W = 10;

  // burst divider
  localparam int BURST_W = 6;
  localparam logic [BURST_W-1:0] DUTY_FULL = 6'h3F;
  localparam logic [4:0] EXT_BASE_DIV = 5'h02;
  localparam logic [4:0] INT_BASE_DIV = 5'h04;

  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int CTRL_RUN_ALLOW = 0;
  localparam int CTRL_PWM_GATE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_STEP_LSB = 0;
  localparam int ST_MODE_LSB = 10;
  localparam int ST_FROZEN = 13;
  localparam int ST_LAMP_LSB = 14;
  localparam int ST_DIM_LSB = 18;
  localparam int ST_REVERSE = 20;
  localparam int ST_BURST = 21;

  typedef enum logic [2:0] {LSBD_OFF, LSBD_POD, LSBD_STRIKE, LSBD_RUN, LSBD_FAULT} lsbd_mode_t;
  typedef enum logic [1:0] {LSBD_DIM_ANALOG, LSBD_DIM_EXT, LSBD_DIM_INT} lsbd_dim_t;

  typedef struct packed {
    logic gate_a;
    logic gate_b;
    logic fault_node;
    logic strike_active;
    logic analog_mode;
    logic reverse;
    logic burst_on;
  } lsbd_drive_t;

  typedef struct packed {
    logic [SYNC_N-1:0] s1;
    logic [SYNC_N-1:0] s2;
    logic [SYNC_N-1:0] s3;
    logic [SYNC_N-1:0] filt;
    logic [SYNC_N-1:0] prev;
    lsbd_mode_t mode;
    logic [TICK_W-1:0] tick_cnt;
    logic [3:0] lamp_cnt;
    logic [STEP_W-1:0] step;
    logic [3:0] step_sub;
    logic frozen;
    logic [3:0] presc;
    logic [BURST_W-1:0] burst_phase;
    lsbd_drive_t drv;
    logic [1:0] ctrl;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } lsbd_state_t;

  localparam lsbd_state_t LSBD_STATE_RST = '{
    s1: '0, s2: '0, s3: '0, filt: '0, prev: '0, mode: LSBD_OFF, tick_cnt: '0, lamp_cnt: '0,
    step: '0, step_sub: '0, frozen: 1'b0, presc: '0, burst_phase: '0, drv: '0,
    ctrl: CTRL_RESET, wr_pend: 1'b0, wr_addr: '0, hrdata: '0, hreadyout: 1'b1};

endpackage : lsbd_pkg

//--- logic/lsbd_sequencer.sv
// lamp sequencer, ignition detector and burst dimmer with AHB-Lite registers
// assumes comparator outputs and tri-state pin decodes arrive asynchronously,
// brightness level comes from a converter on the same clock
//
// What this block does
// - dimming-select picks analog or burst dimming
// - select high: external clock burst, conventional
// - select low: burst from divided run clock
// - polarity pin high conventional, low reverse
// - external clock divided 2/4/8 then 64
// - internal source divides by 4/8/16
// - divider pin high smallest, float middle, low largest
// - external burst: fixed amplitude, duty rises
// - slow brightness PWM gates lamp bursts
// - gates inhibited for 16384 ramp periods
// - power-up or enable starts delay, then strike
// - strike sweeps frequency until overvoltage seen
// - overvoltage freezes frequency until 245760 cycles
// - ignition or timeout removes strike drive
// - eight lamp cycles from strike declares ignition
// - fewer cycles: stay in strike until timeout
// - strike ends after fifteen sweeps without ignition
// - failed ignition or lamp out gives fault
// - run windows of 8192 need eight pulses
// - one strike per supply or enable cycle
// - fault stops gates, drives filter node high
// - undervoltage lockout turns sequencer, gates and fault node off
// - enable low holds state machine reset
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module lsbd_sequencer
  import lsbd_pkg::*;
#(
  parameter int unsigned POD_TICKS = POD_TICKS_DEF,
  parameter int unsigned STRIKE_LIMIT = STRIKE_LIMIT_DEF,
  parameter int unsigned RUN_WINDOW = RUN_WINDOW_DEF
)
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic ENABLE,
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic LAMP_CURRENT_SENSE,
  input wire logic OVERVOLTAGE_SENSE,
  input wire logic RAMP_CLK,
  input wire logic DIM_CLK,
  input wire logic DIM_MODE_HIGH,
  input wire logic DIM_MODE_LOW,
  input wire logic DIV_SEL_HIGH,
  input wire logic DIV_SEL_LOW,
  input wire logic BRIGHTNESS_INPUT,
  input wire logic [BURST_W-1:0] BRIGHTNESS_LEVEL,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic GATE_A,
  output logic GATE_B,
  output logic BRIGHTNESS_FILTER_FAULT_NODE,
  output logic [STEP_W-1:0] STRIKE_FREQ_STEP,
  output logic STRIKE_ACTIVE,
  output logic ANALOG_DIM_MODE,
  output logic REVERSE_POLARITY,
  output logic BURST_ON
);

  localparam logic [TICK_W-1:0] POD_LAST = TICK_W'(POD_TICKS - 1);
  localparam logic [TICK_W-1:0] STRIKE_LAST = TICK_W'(STRIKE_LIMIT - 1);
  localparam logic [TICK_W-1:0] WINDOW_LAST = TICK_W'(RUN_WINDOW - 1);

  logic [1:0] rst_pipe_q;
  logic rst_n;
  lsbd_state_t s_q;
  lsbd_state_t s_d;
  logic [SYNC_N-1:0] pins;
  logic [SYNC_N-1:0] rise;
  logic en_ok;
  logic ramp_tick;
  logic lamp_pulse;
  lsbd_dim_t dim_sel;
  logic [1:0] div_idx;
  logic [4:0] burst_div;
  logic [3:0] presc_last;
  logic burst_src_tick;
  logic reverse;
  logic [BURST_W-1:0] duty;
  logic burst_gate;
  logic [3:0] lamp_next;
  logic ahb_valid;
  logic [31:0] status_word;

  // reset release through two flops
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      rst_pipe_q <= 2'h0;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end

  assign rst_n = rst_pipe_q[1];

  assign pins = {BRIGHTNESS_INPUT, DIV_SEL_LOW, DIV_SEL_HIGH, DIM_MODE_LOW, DIM_MODE_HIGH, DIM_CLK,
                 RAMP_CLK, OVERVOLTAGE_SENSE, LAMP_CURRENT_SENSE, UNDERVOLTAGE_LOCKOUT, ENABLE};
  assign rise = s_q.filt & ~s_q.prev;

  // lockout or enable low forces the sequencer off
  assign en_ok = s_q.filt[SI_ENABLE] & ~s_q.filt[SI_UNDERVOLTAGE_LOCKOUT] & s_q.ctrl[CTRL_RUN_ALLOW];
  assign ramp_tick = rise[SI_RAMP];
  assign lamp_pulse = rise[SI_LAMP];

  // tri-state dimming-select decode
  always_comb
  begin
    if (s_q.filt[SI_DM_HI] && !s_q.filt[SI_DM_LO])
      dim_sel = LSBD_DIM_EXT;
    else if (!s_q.filt[SI_DM_HI] && s_q.filt[SI_DM_LO])
      dim_sel = LSBD_DIM_INT;
    else
      dim_sel = LSBD_DIM_ANALOG;
  end

  // tri-state divider-select decode
  always_comb
  begin
    if (s_q.filt[SI_DV_HI] && !s_q.filt[SI_DV_LO])
      div_idx = 2'h0;
    else if (!s_q.filt[SI_DV_HI] && s_q.filt[SI_DV_LO])
      div_idx = 2'h2;
    else
      div_idx = 2'h1;
  end

  // burst divisor: external 2/4/8, otherwise 4/8/16
  always_comb
  begin
    if (dim_sel == LSBD_DIM_EXT)
      burst_div = EXT_BASE_DIV << div_idx;
    else
      burst_div = INT_BASE_DIV << div_idx;
  end

  assign presc_last = 4'(burst_div - 5'h01);

  // burst source: external dim clock edges or ramp edges
  always_comb
  begin
    if (dim_sel == LSBD_DIM_EXT)
      burst_src_tick = rise[SI_DIMCLK];
    else
      burst_src_tick = ramp_tick;
  end

  // external burst is always conventional
  assign reverse = (dim_sel != LSBD_DIM_EXT) & ~s_q.filt[SI_DIMCLK];
  // reverse polarity inverts the duty code
  always_comb
  begin
    if (reverse)
      duty = ~BRIGHTNESS_LEVEL;
    else
      duty = BRIGHTNESS_LEVEL;
  end
  assign burst_gate = (dim_sel == LSBD_DIM_ANALOG) | (duty == DUTY_FULL) | (s_q.burst_phase < duty);

  // lamp cycle count saturates at the ignition threshold
  always_comb
  begin
    if (lamp_pulse && s_q.lamp_cnt < IGNITE_CYCLES)
      lamp_next = s_q.lamp_cnt + 4'h1;
    else
      lamp_next = s_q.lamp_cnt;
  end

  // ahb address phase and status view
  assign ahb_valid = HSEL & HTRANS[1] & HREADY & (HSIZE == HSIZE_WORD);

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_STEP_LSB +: STEP_W] = s_q.step;
    status_word[ST_MODE_LSB +: 3] = s_q.mode;
    status_word[ST_FROZEN] = s_q.frozen;
    status_word[ST_LAMP_LSB +: 4] = s_q.lamp_cnt;
    status_word[ST_DIM_LSB +: 2] = dim_sel;
    status_word[ST_REVERSE] = reverse;
    status_word[ST_BURST] = s_q.drv.burst_on;
  end

  always_comb
  begin
    s_d = s_q;

    // three-stage synchronisers, a change counts once stages two and three agree
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < SYNC_N; i++)
    begin
      if (s_q.s2[i] == s_q.s3[i])
        s_d.filt[i] = s_q.s3[i];
    end
    s_d.prev = s_q.filt;

    // mode state machine
    unique case (s_q.mode)
      LSBD_OFF:
      begin
        s_d.tick_cnt = '0;
        if (en_ok)
          s_d.mode = LSBD_POD;
      end
      LSBD_POD:
      begin
        if (ramp_tick)
        begin
          s_d.tick_cnt = s_q.tick_cnt + TICK_W'(1);
          if (s_q.tick_cnt == POD_LAST)
          begin
            s_d.mode = LSBD_STRIKE;
            s_d.tick_cnt = '0;
            s_d.lamp_cnt = '0;
            s_d.step = '0;
            s_d.step_sub = '0;
            s_d.frozen = 1'b0;
          end
        end
      end
      LSBD_STRIKE:
      begin
        s_d.lamp_cnt = lamp_next;
        if (s_q.filt[SI_OV])
          s_d.frozen = 1'b1;
        if (ramp_tick)
        begin
          s_d.tick_cnt = s_q.tick_cnt + TICK_W'(1);
          if (!s_q.frozen && !s_q.filt[SI_OV])
          begin
            s_d.step_sub = s_q.step_sub + 4'h1;
            if (s_q.step_sub == PULSES_PER_STEP_LAST)
              s_d.step = s_q.step + STEP_W'(1);
          end
        end
        if (lamp_next >= IGNITE_CYCLES)
        begin
          s_d.mode = LSBD_RUN;
          s_d.tick_cnt = '0;
          s_d.lamp_cnt = '0;
          s_d.step = '0;
          s_d.frozen = 1'b0;
        end
        else if (ramp_tick && s_q.tick_cnt == STRIKE_LAST)
        begin
          // strike step returns to rest so the idle step reads zero
          s_d.mode = LSBD_FAULT;
          s_d.step = '0;
          s_d.step_sub = '0;
          s_d.frozen = 1'b0;
        end
      end
      LSBD_RUN:
      begin
        s_d.lamp_cnt = lamp_next;
        if (ramp_tick)
        begin
          s_d.tick_cnt = s_q.tick_cnt + TICK_W'(1);
          if (s_q.tick_cnt == WINDOW_LAST)
          begin
            s_d.tick_cnt = '0;
            s_d.lamp_cnt = '0;
            if (lamp_next < RUN_MIN_PULSES)
              s_d.mode = LSBD_FAULT;
          end
        end
      end
      LSBD_FAULT:
      begin
        // fault holds until enable drops, no strike retry
        s_d.tick_cnt = '0;
      end
    endcase

    // enable low or lockout holds the machine reset
    if (!en_ok)
    begin
      s_d.mode = LSBD_OFF;
      s_d.tick_cnt = '0;
      s_d.lamp_cnt = '0;
      s_d.step = '0;
      s_d.step_sub = '0;
      s_d.frozen = 1'b0;
    end

    // burst ramp: prescale then a 64-step phase
    if (!en_ok)
    begin
      s_d.presc = '0;
      s_d.burst_phase = '0;
    end
    else if (burst_src_tick)
    begin
      if (s_q.presc >= presc_last)
      begin
        s_d.presc = '0;
        s_d.burst_phase = s_q.burst_phase + BURST_W'(1);
      end
      else
        s_d.presc = s_q.presc + 4'h1;
    end

    // gate drive and status pins
    s_d.drv.burst_on = burst_gate & (~s_q.ctrl[CTRL_PWM_GATE] | s_q.filt[SI_PWM]);
    // gates follow the registered mode, so any mode change
    // drops both drives for one clock before the new mode drives
    s_d.drv.strike_active = (s_q.mode == LSBD_STRIKE) && (s_d.mode == LSBD_STRIKE);
    s_d.drv.gate_a = s_d.drv.strike_active | ((s_q.mode == LSBD_RUN) & (s_d.mode == LSBD_RUN)
                     & s_q.drv.burst_on);
    s_d.drv.gate_b = s_d.drv.gate_a & ~s_q.filt[SI_RAMP];
    s_d.drv.gate_a = s_d.drv.gate_a & s_q.filt[SI_RAMP];
    s_d.drv.fault_node = (s_d.mode == LSBD_FAULT);
    s_d.drv.analog_mode = (dim_sel == LSBD_DIM_ANALOG);
    s_d.drv.reverse = reverse;

    // ahb-lite slave, zero wait states, always okay
    s_d.hreadyout = 1'b1;
    s_d.wr_pend = ahb_valid & HWRITE;
    s_d.wr_addr = HADDR[ADDR_W-1:0];
    if (s_q.wr_pend && s_q.wr_addr == ADDR_CTRL)
      s_d.ctrl = HWDATA[1:0];
    if (ahb_valid && !HWRITE)
    begin
      if (HADDR[ADDR_W-1:0] == ADDR_CTRL)
        s_d.hrdata = {30'h0000_0000, s_q.ctrl};
      else if (HADDR[ADDR_W-1:0] == ADDR_STATUS)
        s_d.hrdata = status_word;
      else
        s_d.hrdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= LSBD_STATE_RST;
    else
      s_q <= s_d;
  end

  assign HRDATA = s_q.hrdata;
  assign HREADYOUT = s_q.hreadyout;
  assign HRESP = 1'b0;
  assign GATE_A = s_q.drv.gate_a;
  assign GATE_B = s_q.drv.gate_b;
  assign BRIGHTNESS_FILTER_FAULT_NODE = s_q.drv.fault_node;
  assign STRIKE_FREQ_STEP = s_q.step;
  assign STRIKE_ACTIVE = s_q.drv.strike_active;
  assign ANALOG_DIM_MODE = s_q.drv.analog_mode;
  assign REVERSE_POLARITY = s_q.drv.reverse;
  assign BURST_ON = s_q.drv.burst_on;

endmodule : lsbd_sequencer

`default_nettype wire

//--- testbench/lsbd_checker_asserts.sv
// port checker of the lamp sequencer
// assumes binding to the sequencer top, ramp clock much slower than CLOCK
`timescale 1ns/100ps
`default_nettype none
module lsbd_checker
  import lsbd_pkg::*;
#(
  parameter int unsigned POD_TICKS = POD_TICKS_DEF
)
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic ENABLE,
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic OVERVOLTAGE_SENSE,
  input wire logic RAMP_CLK,
  input wire logic GATE_A,
  input wire logic GATE_B,
  input wire logic BRIGHTNESS_FILTER_FAULT_NODE,
  input wire logic [STEP_W-1:0] STRIKE_FREQ_STEP,
  input wire logic STRIKE_ACTIVE
);
  logic [TICK_W-1:0] pod_q;
  wire logic off_w = !GATE_A && !GATE_B && !STRIKE_ACTIVE;
  wire logic flt_w = BRIGHTNESS_FILTER_FAULT_NODE;
  // raw ramp edges since enable, always ahead of the synchronised count
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      pod_q <= '0;
    else
      pod_q <= !ENABLE ? '0 : pod_q + TICK_W'($rose(RAMP_CLK) && pod_q < POD_TICKS);
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  AST_POD_GATES: assert property (ENABLE && pod_q < POD_TICKS |-> !GATE_A && !GATE_B)
    else $error("gate driven in power-on delay");
  AST_FAULT_OFF: assert property (flt_w |-> off_w)
    else $error("drive active in fault");
  AST_ENABLE_OFF: assert property (!ENABLE [*8] |=> off_w && !flt_w)
    else $error("active while disabled");
  AST_UNDERVOLTAGE_LOCKOUT_OFF: assert property (UNDERVOLTAGE_LOCKOUT [*8] |=> off_w)
    else $error("active in lockout");
  AST_STEP_IDLE: assert property (!STRIKE_ACTIVE |-> STRIKE_FREQ_STEP == '0)
    else $error("strike step outside strike");
  AST_STEP_INC: assert property (STRIKE_ACTIVE && $past(STRIKE_ACTIVE) && $changed(STRIKE_FREQ_STEP)
    |-> STRIKE_FREQ_STEP == $past(STRIKE_FREQ_STEP) + 10'h001)
    else $error("strike step jumped");
  AST_OV_FREEZE: assert property (OVERVOLTAGE_SENSE [*8] ##0 STRIKE_ACTIVE |=> !STRIKE_ACTIVE ||
    $stable(STRIKE_FREQ_STEP))
    else $error("step moved under overvoltage");
  AST_FAULT_HOLD: assert property ((ENABLE && !UNDERVOLTAGE_LOCKOUT) [*8] ##0 flt_w |=> flt_w)
    else $error("fault cleared while enabled");
  cover property ($rose(STRIKE_ACTIVE));
  cover property ($rose(flt_w));
  cover property ($fell(STRIKE_ACTIVE) && !flt_w);
endmodule : lsbd_checker
bind lsbd_sequencer lsbd_checker #(.POD_TICKS(POD_TICKS)) chk_u (.CLOCK(CLOCK), .NRST(NRST), .ENABLE(ENABLE),
  .UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT), .OVERVOLTAGE_SENSE(OVERVOLTAGE_SENSE), .RAMP_CLK(RAMP_CLK),
  .GATE_A(GATE_A), .GATE_B(GATE_B), .BRIGHTNESS_FILTER_FAULT_NODE(BRIGHTNESS_FILTER_FAULT_NODE),
  .STRIKE_FREQ_STEP(STRIKE_FREQ_STEP), .STRIKE_ACTIVE(STRIKE_ACTIVE));
`default_nettype wire

//--- testbench/lsbd_power_stage.sv
// power stage, lamp comparators and dimming clock source
// assumes lamp current flows only when lit and driven by gate A
`timescale 1ns/100ps
`default_nettype none
module lsbd_power_stage
(
  input wire logic gate_a,
  input wire logic strike,
  input wire logic lit,
  input wire logic ov_req,
  input wire logic ext_clk,
  input wire logic pol,
  output logic ramp,
  output logic lamp,
  output logic ov,
  output logic dim
);
  logic osc;
  initial
  begin
    ramp = 1'b0;
    osc = 1'b0;
    fork
      forever #100 ramp = ~ramp;
      forever #125 osc = ~osc;
    join
  end
  assign lamp = lit & gate_a;
  assign ov = ov_req & strike;
  assign dim = ext_clk ? osc : pol;
endmodule : lsbd_power_stage
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench of the lamp sequencer and burst dimmer
// assumes the checker is bound in and the power stage model drives the analog side
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lsbd_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, en = 1'b0, undervoltage_lockout = 1'b0, mh = 1'b0, ml = 1'b0, dh = 1'b0, dl = 1'b0;
  logic bin = 1'b0, lit = 1'b0, ov_req = 1'b0, ext = 1'b0, pol = 1'b1, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = '0, hwdata = '0, rd_v, hrdata;
  logic [5:0] lvl = 6'h20;
  logic [7:0] lfsr = 8'h21;
  logic [63:0] exp_q[$];
  logic hready, ramp, lamp, ov, dim, gate_a, strike, fault, burst;
  int error_cnt = 0, tests_run = 0;
  event rd_ev;
  lsbd_sequencer #(.POD_TICKS(16), .STRIKE_LIMIT(240), .RUN_WINDOW(32)) dut_u (.CLOCK(clk), .NRST(nrst),
    .ENABLE(en), .UNDERVOLTAGE_LOCKOUT(undervoltage_lockout), .LAMP_CURRENT_SENSE(lamp), .OVERVOLTAGE_SENSE(ov), .RAMP_CLK(ramp),
    .DIM_CLK(dim), .DIM_MODE_HIGH(mh), .DIM_MODE_LOW(ml), .DIV_SEL_HIGH(dh), .DIV_SEL_LOW(dl),
    .BRIGHTNESS_INPUT(bin), .BRIGHTNESS_LEVEL(lvl), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
    .GATE_A(gate_a), .GATE_B(), .BRIGHTNESS_FILTER_FAULT_NODE(fault), .STRIKE_FREQ_STEP(), .STRIKE_ACTIVE(strike),
    .ANALOG_DIM_MODE(), .REVERSE_POLARITY(), .BURST_ON(burst));
  lsbd_power_stage pwr_u (.gate_a(gate_a), .strike(strike), .lit(lit), .ov_req(ov_req), .ext_clk(ext), .pol(pol),
    .ramp(ramp), .lamp(lamp), .ov(ov), .dim(dim));
  initial
  forever #12.5 clk = ~clk;
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task tally_and_finish;
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] result expected %h seen %h", e, s);
    end
  endtask : chk
  // compares each noted expectation, under its mask, with the value that appears
  initial
  forever
  begin
    @(rd_ev);
    chk(rd_v & exp_q[0][63:32], exp_q[0][31:0]);
    void'(exp_q.pop_front());
  end
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    if (!w)
    begin
      exp_q.push_back({m, e});
      rd_v = hrdata;
      ->rd_ev;
    end
  endtask : ahb
  // clocks between burst starts, after one settling period
  task period(input int n);
    longint t0;
    @(posedge burst);
    @(posedge burst);
    t0 = $time;
    @(posedge burst);
    exp_q.push_back({32'hFFFFFFFF, 32'(n)});
    rd_v = 32'(($time - t0) / 25);
    ->rd_ev;
    @(posedge clk);
  endtask : period
  initial
  begin
    #(25 * 97000);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(0, ADDR_CTRL, 0, '1, 32'h1);
    ahb(0, 8'h08, 0, '1, 32'h0);
    ahb(1, ADDR_CTRL, 32'h3, 0, 0);
    repeat (8) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h200000, 32'h0);
    bin <= 1'b1;
    repeat (8) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h200000, 32'h200000);
    ahb(1, ADDR_CTRL, 32'h1, 0, 0);
    for (int i = 0; i < 6; i++)
    begin
      {mh, ml} <= 2'(i / 2);
      pol <= i[0];
      ext <= (i / 2 == 2);
      lfsr = lfsr_next(lfsr);
      lvl <= lfsr[5:0];
      repeat (12) @(posedge clk);
      ahb(0, ADDR_STATUS, 0, 32'h1C0000, 32'({i < 4 && !i[0], i / 2 == 1, i / 2 == 2}) << 18);
    end
    lvl <= 6'h20;
    en <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      {mh, ml} <= (i < 3) ? 2'h1 : 2'h2;
      ext <= (i >= 3);
      {dh, dl} <= (i % 3 == 0) ? 2'h2 : (i % 3 == 2) ? 2'h1 : 2'h0;
      period(64 * ((i < 3) ? 8 * (4 << (i % 3)) : 10 * (2 << (i % 3))));
    end
    en <= 1'b0;
    repeat (12) @(posedge clk);
    {mh, ml} <= 2'h0;
    ext <= 1'b0;
    ov_req <= 1'b1;
    en <= 1'b1;
    repeat (12) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h1C00, 32'h400);
    @(posedge clk iff strike === 1'b1);
    repeat (12) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h3C00, 32'h2800);
    lit <= 1'b1;
    @(posedge clk iff strike === 1'b0);
    repeat (800) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h1C00, 32'hC00);
    lit <= 1'b0;
    @(posedge clk iff fault === 1'b1);
    ahb(0, ADDR_STATUS, 0, 32'h1C00, 32'h1000);
    en <= 1'b0;
    ov_req <= 1'b0;
    repeat (12) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h1C00, 32'h0);
    en <= 1'b1;
    @(posedge clk iff fault === 1'b1);
    repeat (600) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h1C00, 32'h1000);
    undervoltage_lockout <= 1'b1;
    repeat (12) @(posedge clk);
    ahb(0, ADDR_STATUS, 0, 32'h1C00, 32'h0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
